//--- execlist_pkg.sv
package execlist_pkg;
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int DESC_W = 64;
  // descriptor field layout
  localparam int VALID_BIT = 0;
  localparam int ASPACE_LSB = 1;
  localparam int ASPACE_W = 2;
  localparam int IMG_LSB = 12;
  localparam int IMG_W = 20;
  localparam int CTXID_LSB = 32;
  localparam int CTXID_W = 32;
  localparam logic [DESC_W-1:0] DESC_RESET = 64'h0000_0000_0000_0000;
  localparam int ENG_ID_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESTORE = 3'b001,
    ST_RUN = 3'b010,
    ST_SAVE = 3'b011,
    ST_PREEMPT = 3'b100,
    ST_FAULT = 3'b101
  } exec_state_e;
endpackage

//--- execlist_submit_queue.sv
`timescale 1ns/1ps
// How it works
// RULE_01: software submits by writing a descriptor to the submit port
// RULE_02: descriptor holds context id, address space, image address, valid flag
// RULE_03: staging queue keeps eight descriptor entries
// RULE_04: submit writes fill slots 0 to 7 cyclically, then wrap
// RULE_05: each staging entry readable and writable at its own index
// RULE_06: all-invalid queue accepted and treated as empty
// RULE_07: writing staging entries never starts execution
// RULE_08: load copies staging into execution queue and marks it valid
// RULE_09: valid entries run in order slot 0 to 7, invalid skipped
// RULE_10: after slot 7 finishes the execution queue goes invalid, engine idle
// RULE_11: switched-out contexts leave the execution queue; only reload returns them
// RULE_12: staging contents survive loads untouched
// RULE_13: load during execution recopies, preempts, restarts at slot 0
// RULE_14: loads during preemption keep only the newest queue
// RULE_15: nothing runs unless the list-submission enable bit is set; while clear LOAD is refused and idle clears EXEC_Q_VALID, but a loaded list still runs
// RULE_16: save state to image address on switch out, restore on switch in
// RULE_17: software submits only to the engine type matching the image
// RULE_18: direct submission number combines context id, engine id, counter
// RULE_19: engine id from the wait fifo picks which engine waits or readies
// RULE_20: proxy work runs in arrival order; driver id sits in upper half
// RULE_21: a workload at a wait event keeps its queue position
// RULE_22: page fault blocks other contexts on this engine; may preempt to idle
module execlist_submit_queue #(
  parameter int ENGINE_ID = 0
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic LIST_ENABLE,
  input wire logic SUBMIT_WR,
  input wire logic [63:0] SUBMIT_DATA,
  input wire logic ENTRY_WR,
  input wire logic [2:0] ENTRY_IDX,
  input wire logic [63:0] ENTRY_WDATA,
  input wire logic [2:0] ENTRY_RIDX,
  output logic [63:0] ENTRY_RDATA,
  input wire logic LOAD,
  input wire logic CTX_DONE,
  input wire logic PREEMPT_ACK,
  input wire logic MEM_DONE,
  input wire logic WAIT_EVENT,
  input wire logic FAULT_EVENT,
  input wire logic FAULT_IDLE,
  input wire logic RESUME_VALID,
  input wire logic [3:0] RESUME_ENGINE,
  output logic MEM_REQ,
  output logic MEM_SAVE,
  output logic [19:0] MEM_ADDR,
  output logic PREEMPT_REQ,
  output logic RUN_ACTIVE,
  output logic RUN_WAITING,
  output logic [31:0] RUN_CTX_ID,
  output logic [1:0] RUN_ASPACE,
  output logic [2:0] RUN_SLOT,
  output logic EXEC_Q_VALID,
  output logic [2:0] SUBMIT_PTR
);
  typedef struct packed {
    logic [execlist_pkg::NUM_SLOTS-1:0][execlist_pkg::DESC_W-1:0] stage; // RULE_03
    logic [execlist_pkg::NUM_SLOTS-1:0][execlist_pkg::DESC_W-1:0] exec;
    logic [execlist_pkg::SLOT_W-1:0] wptr;
    logic [execlist_pkg::SLOT_W-1:0] slot;
    logic eq_valid;
    logic pend_load;
    logic waiting;
    logic to_idle;
    logic [63:0] rdata;
    logic [63:0] held;
    execlist_pkg::exec_state_e st;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  function automatic logic [execlist_pkg::IMG_W-1:0] img_of(input logic [63:0] d);
    img_of = d[execlist_pkg::IMG_LSB +: execlist_pkg::IMG_W];
  endfunction

  // first valid slot at or after start; found flag in top bit
  function automatic logic [3:0] next_valid(
    input logic [execlist_pkg::NUM_SLOTS-1:0][63:0] q,
    input logic [3:0] start
  );
    logic [3:0] r;
    r = 4'h0;
    for (int i = execlist_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (4'(i) >= start && q[i][execlist_pkg::VALID_BIT]) begin
        r = {1'b1, 3'(i)};
      end
    end
    next_valid = r;
  endfunction

  logic [3:0] hit0;
  logic [3:0] hitn;
  logic [63:0] cur_desc;
  logic resume_me;

  always_comb begin
    nxt_ff = cur_ff;
    // a pending load has replaced the queue; the running descriptor lives in held
    cur_desc = cur_ff.pend_load ? cur_ff.held : cur_ff.exec[cur_ff.slot];
    hit0 = next_valid(cur_ff.exec, 4'h0);
    hitn = next_valid(cur_ff.exec, {1'b0, cur_ff.slot} + 4'h1);
    resume_me = RESUME_VALID && (RESUME_ENGINE == 4'(ENGINE_ID)); // RULE_19
    nxt_ff.rdata = cur_ff.stage[ENTRY_RIDX]; // RULE_05
    // staging writes only store, never start anything
    if (SUBMIT_WR) begin // RULE_01 RULE_07
      nxt_ff.stage[cur_ff.wptr] = SUBMIT_DATA; // RULE_04
      nxt_ff.wptr = cur_ff.wptr + 3'h1; // RULE_04
    end
    if (ENTRY_WR) begin
      nxt_ff.stage[ENTRY_IDX] = ENTRY_WDATA; // RULE_05
    end
    unique case (cur_ff.st)
      execlist_pkg::ST_IDLE: begin
        if (cur_ff.eq_valid) begin
          if (hit0[3]) begin // RULE_06
            nxt_ff.slot = hit0[2:0]; // RULE_09
            nxt_ff.st = execlist_pkg::ST_RESTORE; // RULE_16
          end else begin
            nxt_ff.eq_valid = 1'b0; // RULE_06
          end
        end
      end
      execlist_pkg::ST_RESTORE: begin
        if (MEM_DONE) begin
          nxt_ff.st = execlist_pkg::ST_RUN;
        end
      end
      execlist_pkg::ST_RUN: begin
        if (cur_ff.waiting) begin
          // stays in place while waiting
          if (resume_me) begin
            nxt_ff.waiting = 1'b0; // RULE_21
          end
        end else if (FAULT_EVENT) begin
          nxt_ff.st = execlist_pkg::ST_FAULT; // RULE_22
        end else if (WAIT_EVENT) begin
          nxt_ff.waiting = 1'b1; // RULE_21
        end else if (CTX_DONE) begin
          nxt_ff.st = execlist_pkg::ST_SAVE; // RULE_16
        end
      end
      execlist_pkg::ST_FAULT: begin
        // no other context may run while the fault is open
        if (resume_me) begin
          nxt_ff.st = execlist_pkg::ST_RUN; // RULE_22
        end else if (FAULT_IDLE) begin
          nxt_ff.to_idle = 1'b1; // RULE_22
          nxt_ff.st = execlist_pkg::ST_PREEMPT;
        end
      end
      execlist_pkg::ST_PREEMPT: begin
        if (PREEMPT_ACK) begin
          nxt_ff.st = execlist_pkg::ST_SAVE; // RULE_13
        end
      end
      execlist_pkg::ST_SAVE: begin
        if (MEM_DONE) begin
          if (!cur_ff.pend_load) begin
            nxt_ff.exec[cur_ff.slot][execlist_pkg::VALID_BIT] = 1'b0; // RULE_11
          end
          nxt_ff.waiting = 1'b0;
          if (cur_ff.pend_load || cur_ff.to_idle) begin
            nxt_ff.pend_load = 1'b0;
            nxt_ff.to_idle = 1'b0;
            nxt_ff.st = execlist_pkg::ST_IDLE; // RULE_13
            if (cur_ff.to_idle && !cur_ff.pend_load) begin
              nxt_ff.eq_valid = 1'b0;
            end
          end else if (hitn[3]) begin
            nxt_ff.slot = hitn[2:0]; // RULE_09
            nxt_ff.st = execlist_pkg::ST_RESTORE; // RULE_16
          end else begin
            nxt_ff.eq_valid = 1'b0; // RULE_10
            nxt_ff.st = execlist_pkg::ST_IDLE; // RULE_10
          end
        end
      end
      default: nxt_ff.st = execlist_pkg::ST_IDLE;
    endcase
    // load: snapshot staging; the staging copy itself is left untouched
    if (LOAD && LIST_ENABLE) begin // RULE_15
      nxt_ff.exec = cur_ff.stage; // RULE_08 RULE_12
      nxt_ff.eq_valid = 1'b1; // RULE_08
      if (cur_ff.st != execlist_pkg::ST_IDLE) begin
        nxt_ff.pend_load = 1'b1; // RULE_14
        if (cur_ff.st == execlist_pkg::ST_RUN || cur_ff.st == execlist_pkg::ST_FAULT) begin
          nxt_ff.st = execlist_pkg::ST_PREEMPT; // RULE_13
        end
        // keep the running descriptor so its save still targets the old image
        nxt_ff.held = cur_desc; // RULE_14
        if (cur_ff.st == execlist_pkg::ST_SAVE && MEM_DONE) begin
          nxt_ff.pend_load = 1'b0;
          nxt_ff.to_idle = 1'b0;
          nxt_ff.waiting = 1'b0;
          nxt_ff.st = execlist_pkg::ST_IDLE;
        end
      end
    end
    if (!LIST_ENABLE && cur_ff.st == execlist_pkg::ST_IDLE) begin
      nxt_ff.eq_valid = 1'b0; // RULE_15
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign ENTRY_RDATA = cur_ff.rdata;
  assign MEM_REQ = (cur_ff.st == execlist_pkg::ST_RESTORE) || (cur_ff.st == execlist_pkg::ST_SAVE);
  assign MEM_SAVE = (cur_ff.st == execlist_pkg::ST_SAVE);
  assign MEM_ADDR = MEM_REQ ? img_of(cur_desc) : 20'h00000; // RULE_16
  assign PREEMPT_REQ = (cur_ff.st == execlist_pkg::ST_PREEMPT);
  assign RUN_ACTIVE = (cur_ff.st == execlist_pkg::ST_RUN);
  assign RUN_WAITING = cur_ff.waiting || (cur_ff.st == execlist_pkg::ST_FAULT);
  assign RUN_CTX_ID = cur_desc[execlist_pkg::CTXID_LSB +: execlist_pkg::CTXID_W]; // RULE_02
  assign RUN_ASPACE = cur_desc[execlist_pkg::ASPACE_LSB +: execlist_pkg::ASPACE_W];
  assign RUN_SLOT = cur_ff.slot;
  assign EXEC_Q_VALID = cur_ff.eq_valid;
  assign SUBMIT_PTR = cur_ff.wptr;
endmodule

//--- execlist_submit_queue_properties.sv
`timescale 1ns/1ps
module execlist_submit_queue_properties (
  input wire logic CLK_SYS, RST_N, LIST_ENABLE, SUBMIT_WR, ENTRY_WR, LOAD, PREEMPT_ACK,
  input wire logic [2:0] ENTRY_IDX, ENTRY_RIDX, SUBMIT_PTR,
  input wire logic [63:0] ENTRY_WDATA, ENTRY_RDATA,
  input wire logic RESUME_VALID, FAULT_IDLE, PREEMPT_REQ,
  input wire logic RUN_ACTIVE, RUN_WAITING, EXEC_Q_VALID, MEM_SAVE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  load_copy_a: assert property (LIST_ENABLE && LOAD |=> EXEC_Q_VALID)
    else $error("queue not valid after load");
  load_refused_a: assert property (!LIST_ENABLE && !EXEC_Q_VALID |=> !EXEC_Q_VALID)
    else $error("queue valid while disabled");
  rose_cause_a: assert property ($rose(EXEC_Q_VALID) |-> $past(LOAD && LIST_ENABLE))
    else $error("queue valid without load");
  ptr_wrap_a: assert property (SUBMIT_WR |=> SUBMIT_PTR == $past(SUBMIT_PTR) + 3'h1)
    else $error("submit pointer wrong");
  no_start_a: assert property (!EXEC_Q_VALID && !LOAD |=> !RUN_ACTIVE)
    else $error("run without loaded queue");
  preempt_req_a: assert property (LIST_ENABLE && LOAD && RUN_ACTIVE |=> PREEMPT_REQ)
    else $error("no preempt request");
  preempt_hold_a: assert property (PREEMPT_REQ && !PREEMPT_ACK |=> PREEMPT_REQ)
    else $error("preempt request dropped");
  read_back_a: assert property ((ENTRY_WR && ENTRY_RIDX == ENTRY_IDX) ##1
    (!ENTRY_WR && !SUBMIT_WR && $stable(ENTRY_RIDX)) |=> ENTRY_RDATA == $past(ENTRY_WDATA, 2))
    else $error("entry read back wrong");
  wait_hold_a: assert property (RUN_WAITING && !RESUME_VALID && !FAULT_IDLE && !LOAD && !MEM_SAVE
    |=> RUN_WAITING)
    else $error("wait left without resume");
  cover property ($rose(PREEMPT_REQ));
  cover property ($fell(EXEC_Q_VALID));
  cover property ($rose(RUN_WAITING));
endmodule
bind execlist_submit_queue execlist_submit_queue_properties chk_u (.*);

//--- engine_sim.sv
`timescale 1ns/1ps
module engine_sim #(parameter int LAT = 3) (
  input wire logic clk, mem_req, run_active, preempt_req, hold,
  output logic mem_done, ctx_done, preempt_ack
);
  int cnt = 0;
  initial {mem_done, ctx_done, preempt_ack} = 3'h0;
  always @(posedge clk) begin
    #1;
    {mem_done, ctx_done, preempt_ack} = 3'h0;
    if ((mem_req || preempt_req || run_active) && !hold) cnt++;
    else cnt = 0;
    if (cnt == LAT) begin
      cnt = 0;
      if (mem_req) mem_done = 1;
      else if (preempt_req) preempt_ack = 1;
      else ctx_done = 1;
    end
  end
endmodule

//--- test_execlist_submit_queue.sv
`timescale 1ns/1ps
module test_execlist_submit_queue;
  logic CLK_SYS, RST_N, LIST_ENABLE, SUBMIT_WR, ENTRY_WR, LOAD, CTX_DONE, PREEMPT_ACK, MEM_DONE;
  logic WAIT_EVENT, RESUME_VALID, MEM_REQ, MEM_SAVE, PREEMPT_REQ, RUN_ACTIVE, RUN_WAITING;
  logic EXEC_Q_VALID, hold, ra_q, FAULT_EVENT, FAULT_IDLE;
  logic [63:0] SUBMIT_DATA, ENTRY_WDATA, ENTRY_RDATA;
  logic [2:0] ENTRY_IDX, ENTRY_RIDX, RUN_SLOT, SUBMIT_PTR;
  logic [3:0] RESUME_ENGINE;
  logic [31:0] RUN_CTX_ID;
  logic [19:0] MEM_ADDR;
  logic [1:0] RUN_ASPACE;
  logic [34:0] runs[$];
  int failures = 0;
  int checks_done = 0;
  execlist_submit_queue dut_u (.*);
  engine_sim eng_u (.clk(CLK_SYS), .mem_req(MEM_REQ), .run_active(RUN_ACTIVE),
    .preempt_req(PREEMPT_REQ), .hold(hold), .mem_done(MEM_DONE), .ctx_done(CTX_DONE),
    .preempt_ack(PREEMPT_ACK));
  initial begin
    CLK_SYS = 0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  // record slot and id of each context as it starts running
  always @(posedge CLK_SYS) begin
    if (RUN_ACTIVE && !ra_q) runs.push_back({RUN_SLOT, RUN_CTX_ID});
    ra_q <= RUN_ACTIVE;
  end
  function automatic logic [63:0] desc(int id, int img, bit v);
    return {id[31:0], img[19:0], 9'h000, 2'h1, v};
  endfunction
  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic put(int i, logic [63:0] d);
    ENTRY_IDX = i[2:0];
    ENTRY_WDATA = d;
    ENTRY_WR = 1;
    tick();
  endtask
  task automatic peek(int i, logic [63:0] exp);
    ENTRY_RIDX = i[2:0];
    tick(2);
    chk("entry", exp, ENTRY_RDATA);
  endtask
  task automatic load();
    LOAD = 1;
    tick();
    LOAD = 0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 500) begin
      tick();
      n++;
    end
    chk("wait", v, s);
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 6000);
    failures++;
    end_of_test();
  end
  initial begin
    {LIST_ENABLE, SUBMIT_WR, ENTRY_WR, LOAD, WAIT_EVENT, RESUME_VALID, hold, ra_q} = 8'h00;
    {FAULT_EVENT, FAULT_IDLE} = 2'h0;
    {SUBMIT_DATA, ENTRY_WDATA, ENTRY_IDX, ENTRY_RIDX, RESUME_ENGINE} = '0;
    RST_N = 0;
    tick(10);
    RST_N = 1;
    chk("reset", 0, {EXEC_Q_VALID, SUBMIT_PTR, RUN_ACTIVE});
    SUBMIT_WR = 1;
    for (int i = 0; i < 9; i++) begin
      SUBMIT_DATA = desc(i, i, 1);
      tick();
    end
    SUBMIT_WR = 0;
    chk("submit ptr", 1, SUBMIT_PTR);
    peek(0, desc(8, 8, 1));
    peek(7, desc(7, 7, 1));
    chk("idle", 0, {MEM_REQ, RUN_ACTIVE});
    for (int i = 0; i < 8; i++) put(7 - i, desc(16 + 7 - i, 7 - i, (7 - i) inside {2, 5, 7}));
    ENTRY_WR = 0;
    peek(5, desc(21, 5, 1));
    load();
    tick();
    chk("disabled", 0, EXEC_Q_VALID);
    LIST_ENABLE = 1;
    load();
    chk("loaded", 1, EXEC_Q_VALID);
    wait_for(EXEC_Q_VALID, 0);
    tick(20);
    chk("runs", 3, runs.size());
    foreach (runs[k]) chk("run", {k == 0 ? 3'h2 : k == 1 ? 3'h5 : 3'h7,
      k == 0 ? 32'h12 : k == 1 ? 32'h15 : 32'h17}, runs[k]);
    peek(2, desc(18, 2, 1));
    for (int i = 0; i < 8; i++) put(i, 64'h0);
    ENTRY_WR = 0;
    load();
    wait_for(EXEC_Q_VALID, 0);
    chk("empty runs", 3, runs.size());
    put(0, desc(32'hA1, 1, 1));
    ENTRY_WR = 0;
    load();
    wait_for(RUN_ACTIVE, 1);
    hold = 1;
    WAIT_EVENT = 1;
    tick();
    WAIT_EVENT = 0;
    wait_for(RUN_WAITING, 1);
    RESUME_ENGINE = 4'h1;
    RESUME_VALID = 1;
    tick();
    RESUME_VALID = 0;
    tick();
    chk("other engine", 1, RUN_WAITING);
    RESUME_ENGINE = 4'h0;
    RESUME_VALID = 1;
    tick();
    RESUME_VALID = 0;
    wait_for(RUN_WAITING, 0);
    FAULT_EVENT = 1;
    tick();
    FAULT_EVENT = 0;
    chk("fault", 2'b10, {RUN_WAITING, RUN_ACTIVE});
    RESUME_VALID = 1;
    tick();
    RESUME_VALID = 0;
    chk("fault resume", 2'b01, {RUN_WAITING, RUN_ACTIVE});
    put(0, desc(32'hB2, 2, 1));
    ENTRY_WR = 0;
    runs.delete();
    load();
    chk("preempt", 1, PREEMPT_REQ);
    put(0, desc(32'hC3, 3, 1));
    ENTRY_WR = 0;
    load();
    hold = 0;
    wait_for(EXEC_Q_VALID, 0);
    chk("latest only", 1, runs.size());
    chk("restart", {3'h0, 32'hC3}, runs[0]);
    end_of_test();
  end
endmodule
